// file: core/loop_cfg_pkg.sv
// Purpose: Shared constants and types for the loop phase and filter configuration bank
// Assumes: Classic Wishbone slave, 32-bit data, one register per aligned word
// Notes: Register offsets are indices; byte address is four times the index
package loop_cfg_pkg;

  // Register indices (byte address = index * 4)
  localparam logic [11:0] IDX_STEP_LOW = 12'h412;
  localparam logic [11:0] IDX_STEP_HIGH = 12'h413;
  localparam logic [11:0] IDX_SLEW_LOW = 12'h414;
  localparam logic [11:0] IDX_SLEW_HIGH = 12'h415;
  localparam logic [11:0] IDX_CP_CURRENT = 12'h420;
  localparam logic [11:0] IDX_FB_DIV = 12'h421;
  localparam logic [11:0] IDX_FILTER = 12'h422;
  localparam logic [11:0] IDX_BYPASS = 12'h423;
  // Status register holding live phase offset (own choice)
  localparam logic [11:0] IDX_PHASE_NOW = 12'h416;
  // Fixed offset target, 30 bits over four bytes (own choice of placement)
  localparam logic [11:0] IDX_TARGET0 = 12'h40E;
  localparam logic [11:0] IDX_TARGET3 = 12'h411;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CP_CURRENT = 8'h81;
  localparam logic [7:0] RST_FB_DIV = 8'h14;
  localparam logic [7:0] RST_FILTER = 8'h07;
  localparam logic [7:0] BYPASS_MASK = 8'h01;
  localparam logic [7:0] TARGET3_MASK = 8'h3F;

  // Field positions
  localparam int POLE2_HI = 7;
  localparam int POLE2_LO = 6;
  localparam int RZERO_HI = 5;
  localparam int RZERO_LO = 3;
  localparam int CP1_HI = 2;
  localparam int CP1_LO = 0;

  // Slew pacing: one microsecond per unit
  localparam int CLK_MHZ = 250;
  localparam int US_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int MIN_USEFUL_SLEW = 310;

  // Pole-two resistor selection
  typedef enum logic [1:0]
  {
    POLE2_500 = 2'h0,
    POLE2_333 = 2'h1,
    POLE2_250 = 2'h2,
    POLE2_200 = 2'h3
  } pole2_type;

  // Analog loop filter settings bundle
  typedef struct packed
  {
    pole2_type pole_two_resistor;
    logic [2:0] zero_resistor;
    logic [2:0] pole_one_capacitor;
    logic zero_bypass;
    logic [7:0] charge_pump;
    logic [7:0] feedback_divider;
  } analog_cfg_type;

endpackage

// file: core/loop_phase_and_filter_config.sv
// Purpose: Register bank for digital loop phase step, slew limit and analog loop filter
// Assumes: Classic Wishbone slave, ack one cycle after request, one clock
// Notes: Writes to the phase step high byte add the 16-bit step to the fixed offset target while locked
//   Only byte lane zero carries data, except the 32-bit status word read; other lanes are acked and dropped
//   Unmapped indices are acked, read as zero and ignore writes
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module loop_phase_and_filter_config
  import loop_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [13:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic loop_locked_i,
  output logic signed [31:0] phase_offset_o,
  output logic phase_slewing_o,
  output analog_cfg_type analog_cfg_o
);

  // Bank registers
  logic [7:0] phase_step_low;
  logic [7:0] phase_step_high;
  logic [7:0] slew_limit_low;
  logic [7:0] slew_limit_high;
  logic [7:0] charge_pump_current;
  logic [7:0] analog_feedback_divider;
  logic [7:0] loop_filter_select;
  logic [7:0] zero_resistor_bypass;
  logic [7:0] target_byte [4];
  logic signed [31:0] step_accum;
  logic [1:0] lock_sync;
  logic [7:0] us_count;
  logic us_tick;

  // Bus decode
  logic [11:0] idx;
  logic req;
  logic wr;
  logic wr_lane0;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [31:0] next_dat;
  logic [15:0] step_value;
  logic [15:0] slew_value;
  logic signed [31:0] fixed_target;
  logic signed [31:0] full_target;

  // Write strobe for a given register index
  // Shared by the bus writes and the checks so both decode alike
  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  // Word index; the two low address bits are ignored, sel_i picks the byte lanes
  assign idx = adr_i[13:2];
  // A held request is taken once: the pending ack masks it in the answer cycle,
  // so a master that keeps stb up until it sees ack never writes twice
  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i;
  assign wr_lane0 = wr && sel_i[0];
  assign wbyte = dat_i[7:0];
  assign step_value = {phase_step_high, phase_step_low};
  assign slew_value = {slew_limit_high, slew_limit_low};
  // Fixed target is 30 bits wide; bit 29 is its sign
  assign fixed_target = {{2{target_byte[3][5]}}, target_byte[3][5:0],
                         target_byte[2], target_byte[1], target_byte[0]};
  // Applied steps pile up on top of the fixed target
  assign full_target = fixed_target + step_accum;

  // Ack one cycle after a request, dropped the cycle after
  // The write itself lands at the request edge, the same edge that raises ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  // Lock indication arrives from the loop, two flip-flop synchroniser
  // Only the second stage is read, so a metastable first stage never leaks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lock_sync <= 2'b00;
    else
      lock_sync <= {lock_sync[0], loop_locked_i};
  end

  // One microsecond pacing enable
  // Slew limits count per microsecond, so this strobe is the stepper's tick
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      us_count <= '0;
      us_tick <= 1'b0;
    end
    else if (us_count == 8'(US_CYCLES - 1))
    begin
      us_count <= '0;
      us_tick <= 1'b1;
    end
    else
    begin
      us_count <= us_count + 8'h01;
      us_tick <= 1'b0;
    end
  end

  // Phase step and slew limit registers
  // Each half of a 16-bit value is its own byte; the pair is not atomic
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_step_low <= RST_ZERO;
      phase_step_high <= RST_ZERO;
      slew_limit_low <= RST_ZERO;
      slew_limit_high <= RST_ZERO;
    end
    else if (wr_lane0)
    begin
      if (hit(idx, IDX_STEP_LOW))
        phase_step_low <= wbyte;
      if (hit(idx, IDX_STEP_HIGH))
        phase_step_high <= wbyte;
      if (hit(idx, IDX_SLEW_LOW))
        slew_limit_low <= wbyte;
      if (hit(idx, IDX_SLEW_HIGH))
        slew_limit_high <= wbyte;
    end
  end

  // Step accumulator: each write of the high byte applies one step while locked
  // The low byte must be written first; it is only a holding place
  // Writes while unlocked store the value but move nothing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      step_accum <= '0;
    else if (wr_lane0 && hit(idx, IDX_STEP_HIGH) && lock_sync[1])
      step_accum <= step_accum + 32'({wbyte, phase_step_low});
  end

  // Fixed offset target bytes
  // The top byte keeps six bits; its two reserved bits always read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 4; i++)
        target_byte[i] <= RST_ZERO;
    end
    else if (wr_lane0 && idx >= IDX_TARGET0 && idx <= IDX_TARGET3)
    begin
      if (hit(idx, IDX_TARGET3))
        target_byte[3] <= wbyte & TARGET3_MASK;
      else
        target_byte[2'(idx - IDX_TARGET0)] <= wbyte;
    end
  end

  // Analog loop registers
  // Only bit zero of the bypass register can be set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      charge_pump_current <= RST_CP_CURRENT;
      analog_feedback_divider <= RST_FB_DIV;
      loop_filter_select <= RST_FILTER;
      zero_resistor_bypass <= RST_ZERO;
    end
    else if (wr_lane0)
    begin
      if (hit(idx, IDX_CP_CURRENT))
        charge_pump_current <= wbyte;
      if (hit(idx, IDX_FB_DIV))
        analog_feedback_divider <= wbyte;
      if (hit(idx, IDX_FILTER))
        loop_filter_select <= wbyte;
      if (hit(idx, IDX_BYPASS))
        zero_resistor_bypass <= wbyte & BYPASS_MASK;
    end
  end

  // Read multiplexer
  // Mapped indices return their byte in the low lane
  // The status index is widened below to carry the live phase
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (idx)
      IDX_STEP_LOW: rd_byte = phase_step_low;
      IDX_STEP_HIGH: rd_byte = phase_step_high;
      IDX_SLEW_LOW: rd_byte = slew_limit_low;
      IDX_SLEW_HIGH: rd_byte = slew_limit_high;
      IDX_CP_CURRENT: rd_byte = charge_pump_current;
      IDX_FB_DIV: rd_byte = analog_feedback_divider;
      IDX_FILTER: rd_byte = loop_filter_select;
      IDX_BYPASS: rd_byte = zero_resistor_bypass;
      IDX_TARGET0: rd_byte = target_byte[0];
      IDX_TARGET0 + 12'h001: rd_byte = target_byte[1];
      IDX_TARGET0 + 12'h002: rd_byte = target_byte[2];
      IDX_TARGET3: rd_byte = target_byte[3];
      IDX_PHASE_NOW: rd_byte = {7'h00, phase_slewing_o};
      default:
      begin
        rd_byte = RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Unmapped reads return zero; live phase bits 30:0 are returned at the status index
  // Status word: live phase above, slewing flag in bit 0
  assign next_dat = (idx == IDX_PHASE_NOW) ? {phase_offset_o[30:0], phase_slewing_o} :
                    rd_hit ? {24'h000000, rd_byte} : 32'h00000000;

  // Read data register
  // Loaded only on reads so a write never disturbs what was last read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h00000000;
    else if (req && !we_i)
      dat_o <= next_dat;
  end

  // Rate-capped application of the combined offset
  // A zero limit passes the target straight through
  slew_stepper #(
    .WIDTH(32)
  ) slew_stepper_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(us_tick),
    .limit_i(slew_value),
    .target_i(full_target),
    .phase_o(phase_offset_o),
    .slewing_o(phase_slewing_o)
  );

  // Analog loop settings out
  // Codes go out unchanged; turning them into ohms and farads is the loop's job
  assign analog_cfg_o.pole_two_resistor = pole2_type'(loop_filter_select[POLE2_HI:POLE2_LO]);
  assign analog_cfg_o.zero_resistor = loop_filter_select[RZERO_HI:RZERO_LO];
  assign analog_cfg_o.pole_one_capacitor = loop_filter_select[CP1_HI:CP1_LO];
  assign analog_cfg_o.zero_bypass = zero_resistor_bypass[0];
  assign analog_cfg_o.charge_pump = charge_pump_current;
  assign analog_cfg_o.feedback_divider = analog_feedback_divider;

  // Checks on the bank's own behaviour, all on the register clock

  // Reset leaves the phase step and its sum at zero
  a_step_reset_zero: assert property (@(posedge clk_i)
    $fell(rst_i) |-> step_value == 16'h0000 && step_accum == '0)
    else $error("phase step not zero after reset");

  // No step may land while the synchronised lock is low
  a_step_locked_only: assert property (@(posedge clk_i) disable iff (rst_i)
    !lock_sync[1] |=> $stable(step_accum))
    else $error("phase step applied while unlocked");

  // A locked high-byte write adds the whole 16-bit step once
  a_step_added: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && hit(idx, IDX_STEP_HIGH) && lock_sync[1] |=>
      step_accum == $past(step_accum) + 32'({$past(wbyte), phase_step_low}))
    else $error("phase step not added once");

  // Reset leaves the slew cap off
  a_slew_reset_zero: assert property (@(posedge clk_i)
    $fell(rst_i) |-> slew_value == 16'h0000)
    else $error("slew limit not zero after reset");

  // Pole-two code follows bits 7:6 of the written byte
  a_pole2_select: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && hit(idx, IDX_FILTER) |=>
      analog_cfg_o.pole_two_resistor == pole2_type'($past(dat_i[7:6])))
    else $error("pole two resistor code not applied");

  // Bypass follows bit 0 and the reserved bits stay clear
  a_bypass_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && hit(idx, IDX_BYPASS) |=>
      analog_cfg_o.zero_bypass == $past(dat_i[0]) && zero_resistor_bypass[7:1] == 7'h00)
    else $error("zero resistor bypass not applied");

  // A write with lane zero off changes no register
  a_lane_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && !sel_i[0] |=> $stable(step_value) && $stable(slew_value) &&
      $stable(loop_filter_select) && $stable(zero_resistor_bypass))
    else $error("write without lane zero changed a register");

  // Ack answers every taken request exactly one cycle later
  a_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o)
    else $error("request not acked next cycle");

  // Ack is a single-cycle pulse
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held beyond one cycle");

  // Unmapped reads return zero
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && !rd_hit |=> dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  // Read data holds between reads
  a_read_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(req && !we_i) |=> $stable(dat_o))
    else $error("read data changed without a read");

  // Uncapped: once the target stood still a cycle, the phase sits on it
  a_slew_reaches: assert property (@(posedge clk_i) disable iff (rst_i)
    slew_value == 16'h0000 ##1 (slew_value == 16'h0000 && $stable(full_target)) |->
      !phase_slewing_o)
    else $error("uncapped offset not reached");

  // Filter comes up with the 500 ohm pole-two resistor
  a_filter_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> analog_cfg_o.pole_two_resistor == POLE2_500)
    else $error("pole two resistor not 500 after reset");

  // Analog settings come up at their reset codes
  a_analog_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> analog_cfg_o.charge_pump == RST_CP_CURRENT &&
      analog_cfg_o.feedback_divider == RST_FB_DIV && !analog_cfg_o.zero_bypass)
    else $error("analog settings not at reset codes");

  // Main scenarios worth seeing at least once
  c_step_write: cover property (@(posedge clk_i) wr_lane0 && hit(idx, IDX_STEP_HIGH) && lock_sync[1]);
  c_slewing: cover property (@(posedge clk_i) phase_slewing_o && slew_value >= 16'(MIN_USEFUL_SLEW));
  c_bypass_set: cover property (@(posedge clk_i) analog_cfg_o.zero_bypass);
  c_read: cover property (@(posedge clk_i) ack_o && !we_i);
  c_status_read: cover property (@(posedge clk_i) req && !we_i && idx == IDX_PHASE_NOW);

endmodule
`default_nettype wire

// file: core/slew_stepper.sv
// Purpose: Moves the applied phase toward a target at a capped rate
// Assumes: tick_i pulses once per second-fraction base; limit of zero means no cap
// Notes: Rate is limit picoseconds per microsecond tick (us/s equals ps/us)
`timescale 1ns/1ps
`default_nettype none
module slew_stepper
  import loop_cfg_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic [15:0] limit_i,
  input wire logic signed [WIDTH-1:0] target_i,
  output logic signed [WIDTH-1:0] phase_o,
  output logic slewing_o
);

  // Distance still to go and the step allowed this tick
  logic signed [WIDTH-1:0] diff;
  logic signed [WIDTH-1:0] lim;
  logic signed [WIDTH-1:0] next_phase;
  logic big_up;
  logic big_dn;

  assign diff = target_i - phase_o;
  assign lim = WIDTH'(limit_i);
  assign big_up = diff > lim;
  assign big_dn = diff < -lim;
  // Zero limit jumps straight to target, otherwise one capped step per tick
  assign next_phase = (limit_i == 16'h0000) ? target_i :
                      !tick_i ? phase_o :
                      big_up ? phase_o + lim :
                      big_dn ? phase_o - lim : target_i;
  assign slewing_o = diff != '0;

  // Applied phase register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      phase_o <= '0;
    else
      phase_o <= next_phase;
  end

  // Signed step sizes against the limit in force at the edge that took the step
  a_step_capped: assert property (@(posedge clk_i) disable iff (rst_i)
    (limit_i != 16'h0000 && $stable(limit_i)) |=>
      (phase_o - $past(phase_o) <= $past(lim)) &&
      ($past(phase_o) - phase_o <= $past(lim)))
    else $error("phase step exceeds slew limit");

  a_zero_uncapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (limit_i == 16'h0000) |=> phase_o == $past(target_i))
    else $error("zero limit did not apply target at once");

endmodule
`default_nettype wire

// file: tb/loop_phase_and_filter_config_tb_top.sv
// Purpose: Self-checking bench for the loop phase and filter configuration bank
// Assumes: Wishbone classic slave answering in its own time; lock input crosses two flops
// Notes: Directed scenarios only; the design carries its own assertions
`timescale 1ns/1ps
`default_nettype none
module loop_phase_and_filter_config_tb_top
  import loop_cfg_pkg::*;
();
  logic clk_i; // 250 MHz register clock
  logic rst_i; // Synchronous reset, active high
  logic cyc_i, stb_i, we_i; // Bus request lines
  logic [13:0] adr_i; // Byte address
  logic [3:0] sel_i; // Byte selects
  logic [31:0] dat_i; // Write data
  logic [31:0] dat_o; // Read data
  logic ack_o; // Bus answer
  logic loop_locked_i; // Digital loop lock level
  logic signed [31:0] phase_offset_o; // Applied phase offset
  logic phase_slewing_o; // High while offset moves
  analog_cfg_type analog_cfg_o; // Analog loop settings
  int fails; // Mismatch count
  int n_tests; // Comparison count
  int cycles; // Timeout counter

  loop_phase_and_filter_config loop_phase_and_filter_config_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .loop_locked_i(loop_locked_i),
    .phase_offset_o(phase_offset_o), .phase_slewing_o(phase_slewing_o),
    .analog_cfg_o(analog_cfg_o));

  // Clock generator, 4 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Hang guard; a run this long means a stuck handshake
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      results();
    end
  end

  // Compare one value and log a mismatch
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask

  // One classic bus cycle; holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'h0};
    sel_i <= s;
    dat_i <= {24'h000000, d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    chk("ack", 32'h1, {31'h0, ack_o});
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Full-byte write
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, 4'hF, q);
  endtask

  // Read and compare
  task automatic rd(input string n, input logic [11:0] idx, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, 4'hF, q);
    chk(n, {24'h000000, e}, q);
  endtask

  // Reset values of the step, slew and analog registers and of the derived outputs
  task automatic t_reset();
    logic [11:0] ia[8] = '{IDX_STEP_LOW, IDX_STEP_HIGH, IDX_SLEW_LOW, IDX_SLEW_HIGH,
                           IDX_CP_CURRENT, IDX_FB_DIV, IDX_FILTER, IDX_BYPASS};
    logic [7:0] ea[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h14, 8'h07, 8'h00};
    chk("phase_rst", 32'h0, phase_offset_o);
    chk("pole2_rst", {30'h0, POLE2_500}, {30'h0, analog_cfg_o.pole_two_resistor});
    chk("bypass_rst", 32'h0, {31'h0, analog_cfg_o.zero_bypass});
    chk("cp_rst", 32'h81, {24'h0, analog_cfg_o.charge_pump});
    chk("div_rst", 32'h14, {24'h0, analog_cfg_o.feedback_divider});
    chk("rzero_rst", 32'h0, {29'h0, analog_cfg_o.zero_resistor});
    chk("cp1_rst", 32'h7, {29'h0, analog_cfg_o.pole_one_capacitor});
    for (int i = 0; i < 8; i++)
      rd("reg_rst", ia[i], ea[i]);
  endtask

  // Read-back of both 16-bit values, masked write, unmapped place
  task automatic t_rw();
    logic [31:0] q;
    wr(IDX_STEP_LOW, 8'hA5);
    wr(IDX_STEP_HIGH, 8'h5A);
    wr(IDX_SLEW_LOW, 8'h36); // Limit 0x136 is the least useful nonzero
    wr(IDX_SLEW_HIGH, 8'h01);
    wb(1'b1, IDX_STEP_LOW, 8'hFF, 4'hE, q);
    rd("step_low", IDX_STEP_LOW, 8'hA5);
    rd("step_high", IDX_STEP_HIGH, 8'h5A);
    rd("slew_low", IDX_SLEW_LOW, 8'h36);
    rd("slew_high", IDX_SLEW_HIGH, 8'h01);
    chk("phase_unlocked", 32'h0, phase_offset_o);
    wr(12'h430, 8'h77);
    rd("unmapped", 12'h430, 8'h00);
  endtask

  // Every pole-two code, then the zero-resistor bypass bit
  task automatic t_filter();
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_FILTER, {c[1:0], 6'h07});
      chk("pole2", {30'h0, c[1:0]}, {30'h0, analog_cfg_o.pole_two_resistor});
      rd("filter", IDX_FILTER, {c[1:0], 6'h07});
    end
    wr(IDX_BYPASS, 8'hFF);
    rd("bypass", IDX_BYPASS, 8'h01);
    chk("bypass_on", 32'h1, {31'h0, analog_cfg_o.zero_bypass});
    wr(IDX_BYPASS, 8'h00);
    chk("bypass_off", 32'h0, {31'h0, analog_cfg_o.zero_bypass});
    wr(IDX_FILTER, 8'h2A);
    chk("rzero", 32'h5, {29'h0, analog_cfg_o.zero_resistor});
    chk("cp1", 32'h2, {29'h0, analog_cfg_o.pole_one_capacitor});
    chk("pole2_keep", {30'h0, POLE2_500}, {30'h0, analog_cfg_o.pole_two_resistor});
    wr(IDX_CP_CURRENT, 8'h3C);
    wr(IDX_FB_DIV, 8'hC8);
    chk("cp_out", 32'h3C, {24'h0, analog_cfg_o.charge_pump});
    chk("div_out", 32'hC8, {24'h0, analog_cfg_o.feedback_divider});
  endtask

  // Fixed offset move under a 310 limit, then with the cap off
  task automatic t_slew();
    int n;
    wr(IDX_TARGET0 + 12'h001, 8'h04);
    chk("slewing", 32'h1, {31'h0, phase_slewing_o});
    n = 0;
    while (phase_slewing_o !== 1'b0 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("slew_slow", 32'h1, {31'h0, n >= 700}); // Needs four 1 us steps
    chk("slew_bound", 32'h1, {31'h0, n <= 1100});
    chk("slew_end", 32'd1024, phase_offset_o);
    rd("target1", IDX_TARGET0 + 12'h001, 8'h04);
    wr(IDX_SLEW_LOW, 8'h00);
    wr(IDX_SLEW_HIGH, 8'h00);
    wr(IDX_TARGET0 + 12'h001, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("nocap_phase", 32'h0, phase_offset_o);
    chk("nocap_idle", 32'h0, {31'h0, phase_slewing_o});
    wr(IDX_TARGET3, 8'hC0);
    rd("target3", IDX_TARGET3, 8'h00);
    chk("target3_phase", 32'h0, phase_offset_o);
  endtask

  // Step applied on high-byte write only while locked
  task automatic t_step();
    loop_locked_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(IDX_STEP_LOW, 8'h20);
    wr(IDX_STEP_HIGH, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("step_locked", 32'd32, phase_offset_o);
    loop_locked_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(IDX_STEP_HIGH, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("step_unlocked", 32'd32, phase_offset_o);
    rd("status", IDX_PHASE_NOW, 8'h40);
  endtask

  // Verdict and end of run
  task automatic results();
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    fails = 0;
    n_tests = 0;
    cycles = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 14'h0000;
    sel_i = 4'h0;
    dat_i = 32'h00000000;
    loop_locked_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_rw();
    t_filter();
    t_slew();
    t_step();
    results();
  end
endmodule
`default_nettype wire
